// ### design/fault_summary_regs.svh
`ifndef FAULT_SUMMARY_REGS_SVH
`define FAULT_SUMMARY_REGS_SVH

// command codes
`define CMD_SUMMARY_BYTE   8'h78
`define CMD_SUMMARY_WORD   8'h79
`define CMD_AVG_TRIGGER    8'h6B
`define CMD_CLEAR_FAULTS   8'h03

// byte summary bit positions
`define BIT_OFF            6
`define BIT_OUT_OV         5
`define BIT_OUT_OC         4
`define BIT_IN_UV          3
`define BIT_TEMP           2
`define BIT_COMM_FAULT     1
`define BYTE_MSB           7
`define BYTE_LSB           0

// word high byte bit positions
`define BIT_OUT_VOLT_SUM   15
`define BIT_OUT_CURR_SUM   14
`define BIT_INPUT_SUM      13
`define BIT_DATA_RDY       12
`define BIT_PGOOD          11
`define BIT_WDOG           8

// reset and timing values
`define LATCH_RESET        16'h0000
`define READ_ZERO          16'h0000
`define RESULT_RESET       16'h0000
`define ACC_RESET          32'h0000_0000
`define UPPER_ZERO         8'h00
`define AVG_WINDOW_NS      10000
`define CLK_PERIOD_NS      10
`define AVG_WINDOW_CYC     ((`AVG_WINDOW_NS) / (`CLK_PERIOD_NS))
`define WDOG_LIMIT_NS      20000
`define WDOG_LIMIT_CYC     ((`WDOG_LIMIT_NS) / (`CLK_PERIOD_NS))
`define CNT_ZERO           16'h0000
`define CNT_ONE            16'h0001

`endif

// ### design/fault_summary_pkg.sv
package fault_summary_pkg;

  // averaging window sequencer
  typedef enum logic [1:0]
  {
    avg_idle    = 2'b00,
    avg_collect = 2'b01,
    avg_done    = 2'b10
  } avg_state_t;

  typedef logic [15:0] status_word_t;

endpackage : fault_summary_pkg

// ### design/pmbus_fault_status_summary.sv
`timescale 1ns/10ps
`include "fault_summary_regs.svh"

module pmbus_fault_status_summary
  import fault_summary_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_code,
  input  wire logic         cmd_is_read,
  input  wire logic         output_unpowered,
  input  wire logic         power_good_live,
  input  wire logic         output_overvoltage_flag,
  input  wire logic         output_undervoltage_event,
  input  wire logic         output_voltage_warning,
  input  wire logic         output_overcurrent_flag,
  input  wire logic         output_overpower_event,
  input  wire logic         output_current_warning,
  input  wire logic         input_undervoltage_flag,
  input  wire logic         input_other_event,
  input  wire logic         temperature_event,
  input  wire logic         comm_memory_logic_flag,
  input  wire logic         average_mode,
  input  wire logic [15:0]  sample_value,
  input  wire logic         monitor_step,
  output logic              rsp_valid,
  output logic [15:0]       rsp_data,
  output logic [15:0]       averaged_result,
  output logic              monitor_restart
);

  logic         clear_cmd;
  logic         trig_cmd;
  logic         read_byte;
  logic         read_word;
  logic [15:0]  latch_q;
  logic         off_q;
  logic         pgood_q;
  logic         ready_q;
  logic [15:0]  win_cnt_q;
  logic [31:0]  acc_q;
  logic [15:0]  wdog_cnt_q;
  logic         wdog_expire;
  avg_state_t   avg_state_q;
  status_word_t status_now;
  logic         volt_event;
  logic         curr_event;
  logic         input_event;
  logic         win_collect;
  logic         win_last;
  logic [31:0]  acc_next;

  // merge a set and a clear, set winning
  function automatic logic sticky(input logic cur, input logic set_ev, input logic clr);
    sticky = set_ev | (cur & ~clr);
  endfunction : sticky

  // command match: valid, direction and code together
  function automatic logic cmd_hit(input logic       valid,
                                   input logic       is_read,
                                   input logic [7:0] code,
                                   input logic       want_read,
                                   input logic [7:0] want);
    cmd_hit = valid & (is_read == want_read) & (code == want);
  endfunction : cmd_hit

  // command decode; trigger is a bare command code with no data
  assign clear_cmd = cmd_hit(cmd_valid, cmd_is_read, cmd_code, 1'b0, `CMD_CLEAR_FAULTS);
  assign trig_cmd  = cmd_hit(cmd_valid, cmd_is_read, cmd_code, 1'b0, `CMD_AVG_TRIGGER);
  assign read_byte = cmd_hit(cmd_valid, cmd_is_read, cmd_code, 1'b1, `CMD_SUMMARY_BYTE);
  assign read_word = cmd_hit(cmd_valid, cmd_is_read, cmd_code, 1'b1, `CMD_SUMMARY_WORD);
  assign wdog_expire = (wdog_cnt_q == 16'(`WDOG_LIMIT_CYC));

  // summary event merges; each group of detailed sources sets one high-byte bit
  assign volt_event  = output_overvoltage_flag | output_undervoltage_event
                       | output_voltage_warning;
  assign curr_event  = output_overcurrent_flag | output_overpower_event
                       | output_current_warning;
  assign input_event = input_undervoltage_flag | input_other_event;

  // latched fault bits; the only host write that reaches this store is the clear command
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      latch_q <= `LATCH_RESET;
    end
    else
    begin
      latch_q[`BIT_OUT_OV] <= sticky(latch_q[`BIT_OUT_OV], output_overvoltage_flag,
                                     clear_cmd);
      latch_q[`BIT_OUT_OC] <= sticky(latch_q[`BIT_OUT_OC], output_overcurrent_flag,
                                     clear_cmd);
      latch_q[`BIT_IN_UV]  <= sticky(latch_q[`BIT_IN_UV], input_undervoltage_flag,
                                     clear_cmd);
      latch_q[`BIT_TEMP]   <= sticky(latch_q[`BIT_TEMP], temperature_event,
                                     clear_cmd);
      latch_q[`BIT_COMM_FAULT] <= sticky(latch_q[`BIT_COMM_FAULT], comm_memory_logic_flag,
                                         clear_cmd);
      latch_q[`BIT_OUT_VOLT_SUM] <= sticky(latch_q[`BIT_OUT_VOLT_SUM], volt_event,
                                           clear_cmd);
      latch_q[`BIT_OUT_CURR_SUM] <= sticky(latch_q[`BIT_OUT_CURR_SUM], curr_event,
                                           clear_cmd);
      latch_q[`BIT_INPUT_SUM] <= sticky(latch_q[`BIT_INPUT_SUM], input_event,
                                        clear_cmd);
      latch_q[`BIT_WDOG]   <= sticky(latch_q[`BIT_WDOG], wdog_expire, clear_cmd);
    end
  end

  // live bits follow their inputs, one register stage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      off_q   <= 1'b1;
      pgood_q <= 1'b0;
    end
    else
    begin
      off_q   <= output_unpowered;
      pgood_q <= power_good_live;
    end
  end

  // window helpers; the next sum feeds both the accumulator and the divide
  assign win_collect = (avg_state_q == avg_collect);
  assign win_last    = win_collect & (win_cnt_q == (16'(`AVG_WINDOW_CYC) - `CNT_ONE));
  assign acc_next    = acc_q + 32'(sample_value);

  // window sequencer: trigger restarts, counter ends the window
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      avg_state_q <= avg_idle;
      win_cnt_q   <= `CNT_ZERO;
    end
    else if (trig_cmd)
    begin
      avg_state_q <= avg_collect;
      win_cnt_q   <= `CNT_ZERO;
    end
    else
    begin
      case (avg_state_q)
        avg_idle:
        begin
          avg_state_q <= avg_idle;
        end
        avg_collect:
        begin
          win_cnt_q <= win_cnt_q + `CNT_ONE;
          if (win_last)
          begin
            avg_state_q <= avg_done;
          end
        end
        avg_done:
        begin
          avg_state_q <= avg_done;  // done state held until next trigger; averaged_result held until next window end
        end
        default:
        begin
          avg_state_q <= avg_idle;
        end
      endcase
    end
  end

  // accumulator; cleared by the trigger so a stale sum never leaks into a new window
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc_q <= `ACC_RESET;
    end
    else if (trig_cmd)
    begin
      acc_q <= `ACC_RESET;
    end
    else if (win_collect)
    begin
      acc_q <= acc_next;
    end
  end

  // averaged result moves only at window end, so reads stay stable across a retrigger
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      averaged_result <= `RESULT_RESET;
    end
    else if (win_last && !trig_cmd)
    begin
      averaged_result <= 16'(acc_next / 32'(`AVG_WINDOW_CYC));
    end
  end

  // data-ready flag; a trigger beats a window end in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ready_q <= 1'b0;
    end
    else if (trig_cmd)
    begin
      ready_q <= 1'b0;
    end
    else if (win_last)
    begin
      ready_q <= average_mode;
    end
  end

  // monitor watchdog; a step from the monitor machine feeds it, expiry restarts it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wdog_cnt_q <= `CNT_ZERO;
    end
    else if (monitor_step || wdog_expire)
    begin
      wdog_cnt_q <= `CNT_ZERO;
    end
    else
    begin
      wdog_cnt_q <= wdog_cnt_q + `CNT_ONE;
    end
  end

  // restart pulse to the monitor machine, one cycle per expiry
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      monitor_restart <= 1'b0;
    end
    else
    begin
      monitor_restart <= wdog_expire;
    end
  end

  // assemble the word; reserved positions stay zero
  always_comb
  begin
    status_now                 = `READ_ZERO;
    status_now[`BIT_OFF]       = off_q;
    status_now[`BIT_OUT_OV]    = latch_q[`BIT_OUT_OV];
    status_now[`BIT_OUT_OC]    = latch_q[`BIT_OUT_OC];
    status_now[`BIT_IN_UV]     = latch_q[`BIT_IN_UV];
    status_now[`BIT_TEMP]      = latch_q[`BIT_TEMP];
    status_now[`BIT_COMM_FAULT]   = latch_q[`BIT_COMM_FAULT];
    status_now[`BIT_OUT_VOLT_SUM] = latch_q[`BIT_OUT_VOLT_SUM];
    status_now[`BIT_OUT_CURR_SUM] = latch_q[`BIT_OUT_CURR_SUM];
    status_now[`BIT_INPUT_SUM] = latch_q[`BIT_INPUT_SUM];
    status_now[`BIT_DATA_RDY]  = ready_q;
    status_now[`BIT_PGOOD]     = pgood_q;
    status_now[`BIT_WDOG]      = latch_q[`BIT_WDOG];
  end

  // read strobe; a one-cycle pulse one cycle after the request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= read_byte | read_word;
    end
  end

  // read data holds until the next read; byte uses the same low byte
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rsp_data <= `READ_ZERO;
    end
    else if (read_word)
    begin
      rsp_data <= status_now;
    end
    else if (read_byte)
    begin
      rsp_data <= {`UPPER_ZERO, status_now[`BYTE_MSB:`BYTE_LSB]};
    end
  end

endmodule : pmbus_fault_status_summary

// ### verif/fault_summary_props.sv
`timescale 1ns/10ps
module fault_summary_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_is_read,
  input wire logic        output_unpowered,
  input wire logic        power_good_live,
  input wire logic        output_overvoltage_flag,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        monitor_restart
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // decoded reads and clear
  wire rd_w = cmd_valid && cmd_is_read && cmd_code == 8'h79;
  wire rd_b = cmd_valid && cmd_is_read && cmd_code == 8'h78;
  wire clr = cmd_valid && !cmd_is_read && cmd_code == 8'h03;
  read_reply_a:
    assert property ((rd_w || rd_b) |=> rsp_valid) else $error("read without reply");
  write_silent_a:
    assert property (cmd_valid && !cmd_is_read |=> !rsp_valid) else $error("write answered");
  reserved_zero_a:
    assert property (rsp_valid |-> rsp_data[10:9] == 2'b00 && !rsp_data[7] && !rsp_data[0])
    else $error("reserved bit set");
  byte_upper_a:
    assert property (rd_b |=> rsp_data[15:8] == 8'h00) else $error("byte read upper set");
  off_live_a:
    assert property (rd_w |=> rsp_data[6] == $past(output_unpowered, 2)) else $error("off bit");
  pgood_live_a:
    assert property (rd_w |=> rsp_data[11] == $past(power_good_live, 2)) else $error("pgood bit");
  ov_latch_a:
    assert property (output_overvoltage_flag ##1 !clr ##1 rd_w |=> rsp_data[5] && rsp_data[15])
    else $error("ov not latched");
  clear_ov_a:
    assert property (clr && !output_overvoltage_flag ##1 !output_overvoltage_flag ##1 rd_w
                     |=> !rsp_data[5])
    else $error("ov not cleared");
  wdog_flag_a:
    assert property (monitor_restart && !clr ##1 rd_w |=> rsp_data[8])
    else $error("watchdog bit");
endmodule : fault_summary_props

bind pmbus_fault_status_summary fault_summary_props props (.*);

// ### verif/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
  input  wire logic  clock,
  output logic       cmd_valid,
  output logic [7:0] cmd_code,
  output logic       cmd_is_read
);
  // idle bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_is_read = 1'b0;
  end
  // one command, idle cycle before it; fields scrambled once released
  task send(input logic [7:0] code, input logic rd);
    @(posedge clock);
    #1 cmd_valid = 1'b1;
    cmd_code = code;
    cmd_is_read = rd;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_is_read = ~rd;
  endtask : send
endmodule : pmbus_host_model

// ### verif/pmbus_fault_status_summary_test.sv
`timescale 1ns/10ps
module pmbus_fault_status_summary_test;
  import fault_summary_pkg::*;
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         off = 1'b1;
  logic         pg = 1'b0;
  logic         avg = 1'b0;
  logic         mstep = 1'b0;
  logic [9:0]   ev = 10'h000;
  logic [15:0]  smp = 16'h0000;
  logic         cv, rd, rv, mr;
  logic [7:0]   code;
  status_word_t rdat, ares;
  logic [31:0]  seed = 32'hE32C13A2;
  int           failures = 0;
  int           checked = 0;

  pmbus_host_model host (.clock(clock), .cmd_valid(cv), .cmd_code(code), .cmd_is_read(rd));
  pmbus_fault_status_summary uut (
    .clock(clock), .rst(rst), .cmd_valid(cv), .cmd_code(code), .cmd_is_read(rd),
    .output_unpowered(off), .power_good_live(pg),
    .output_overvoltage_flag(ev[9]), .output_undervoltage_event(ev[8]),
    .output_voltage_warning(ev[7]), .output_overcurrent_flag(ev[6]),
    .output_overpower_event(ev[5]), .output_current_warning(ev[4]),
    .input_undervoltage_flag(ev[3]), .input_other_event(ev[2]),
    .temperature_event(ev[1]), .comm_memory_logic_flag(ev[0]),
    .average_mode(avg), .sample_value(smp), .monitor_step(mstep),
    .rsp_valid(rv), .rsp_data(rdat), .averaged_result(ares), .monitor_restart(mr)
  );

  // free-running clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs

  // word expected after one event cycle, no window or watchdog yet
  function automatic status_word_t exp_w(input logic [9:0] e, input logic o, p);
    return {|e[9:7], |e[6:4], |e[3:2], 1'b0, p, 4'h0, o, e[9], e[6], e[3], e[1], e[0], 1'b0};
  endfunction : exp_w

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task rd_reg(input logic [7:0] c, input status_word_t e);
    host.send(c, 1'b1);
    chk("rsp_valid", {15'h0, rv}, 16'h0001);
    chk("rsp_data", rdat, e);
  endtask : rd_reg

  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // hang guard
  initial
  begin
    #1000000;
    failures++;
    summarize();
  end

  initial
  begin
    logic [9:0] e;
    status_word_t w;
    int k;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    host.send(8'h78, 1'b0);
    w = exp_w(10'h000, off, pg);
    rd_reg(8'h78, {8'h00, w[7:0]});
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      off = seed[0];
      pg = seed[1];
      mstep = seed[2];
      e = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : seed[17:8];
      host.send(8'h03, 1'b0);
      ev = e;
      @(posedge clock);
      #1 ev = 10'h000;
      w = exp_w(e, off, pg);
      rd_reg(8'h79, w);
      rd_reg(8'h78, {8'h00, w[7:0]});
    end
    // averaging window, then a retrigger while the old result must hold
    mstep = 1'b0;
    avg = 1'b1;
    smp = 16'h1234;
    host.send(8'h6B, 1'b0);
    repeat (1005) @(posedge clock);
    host.send(8'h79, 1'b1);
    chk("data_ready", {15'h0, rdat[12]}, 16'h0001);
    chk("averaged_result", ares, 16'h1234);
    smp = 16'h0F0F;
    host.send(8'h6B, 1'b0);
    avg = 1'b0;
    host.send(8'h79, 1'b1);
    chk("data_ready", {15'h0, rdat[12]}, 16'h0000);
    chk("averaged_result", ares, 16'h1234);
    // starve the watchdog, bounded wait for its restart pulse
    k = 0;
    while (mr !== 1'b1 && k < 2100)
    begin
      @(posedge clock);
      #1 k++;
    end
    if (mr !== 1'b1)
    begin
      failures++;
    end
    else
    begin
      host.send(8'h79, 1'b1);
      chk("watchdog", {15'h0, rdat[8]}, 16'h0001);
      mstep = 1'b1;
      host.send(8'h03, 1'b0);
      host.send(8'h79, 1'b1);
      chk("watchdog", {15'h0, rdat[8]}, 16'h0000);
      chk("live_bits", {14'h0, rdat[11], rdat[6]}, {14'h0, pg, off});
    end
    // second window ran with averaging mode off: new result, no ready flag
    repeat (1005) @(posedge clock);
    host.send(8'h79, 1'b1);
    chk("data_ready", {15'h0, rdat[12]}, 16'h0000);
    chk("averaged_result", ares, 16'h0F0F);
    summarize();
  end
endmodule : pmbus_fault_status_summary_test
